// File: logic/fts_defs.vh
// Register map, field positions, encodings and timing counts of the frame scheduler
`ifndef FTS_DEFS_VH
`define FTS_DEFS_VH

// ******************************************************
// Register byte offsets
// ******************************************************
`define FTS_A_CTRL     8'h00
`define FTS_A_FRAME_ID 8'h04
`define FTS_A_INTERVAL 8'h08
`define FTS_A_TX_LO    8'h0C
`define FTS_A_TX_HI    8'h10
`define FTS_A_TX_CMD   8'h14
`define FTS_A_TX_STAMP 8'h18
`define FTS_A_RX_LO    8'h1C
`define FTS_A_RX_HI    8'h20
`define FTS_A_RX_INFO  8'h24
`define FTS_A_STATUS   8'h28
`define FTS_A_NOW      8'h2C

// ******************************************************
// Field positions
// ******************************************************
`define FTS_CTRL_EN     0
`define FTS_CTRL_OUT    1
`define FTS_CTRL_STREAM 2
`define FTS_CTRL_TT_LO  3
`define FTS_CTRL_TT_HI  4
`define FTS_CTRL_ST_LO  5
`define FTS_CTRL_ST_HI  6
`define FTS_CMD_RTR     4
`define FTS_INFO_NEW    5
`define FTS_ID_LO       16
`define FTS_ID_HI       26

// ******************************************************
// Encodings
// ******************************************************
`define FTS_TT_CYC_DATA 2'h0
`define FTS_TT_EVT_DATA 2'h1
`define FTS_TT_CYC_RMT  2'h2
`define FTS_TT_EVT_RMT  2'h3
`define FTS_ST_IMM      2'h0
`define FTS_ST_RPL_EXC  2'h1
`define FTS_ST_RPL_INC  2'h2

// ******************************************************
// Reset values and timing
// ******************************************************
`define FTS_CTRL_RST     7'h00
`define FTS_INTERVAL_RST 16'h0064
`define FTS_CLK_NS       25
`define FTS_TICK_NS      1000
`define FTS_TICK_CYC     ((`FTS_TICK_NS + `FTS_CLK_NS - 1) / `FTS_CLK_NS)

`endif

// File: logic/fts_interval_timer.v
// Transmit interval timer that reloads at each timed send
`timescale 1ns/10ps
module fts_interval_timer #(
  parameter IW = 16
) (
  input  wire          i_clk,
  input  wire          i_resetn,
  input  wire          i_tick,
  input  wire          i_clear,
  input  wire          i_reload,
  input  wire [IW-1:0] i_interval,
  output wire          o_expired
);

  reg [IW-1:0] count_q;

  // ******************************************************
  // Down counter, zero means expired
  // ******************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= {IW{1'b0}};
    end else if (i_clear) begin
      count_q <= {IW{1'b0}};
    end else if (i_reload) begin
      count_q <= i_interval;
    end else if (i_tick && count_q != {IW{1'b0}}) begin
      count_q <= count_q - {{(IW-1){1'b0}}, 1'b1};
    end
  end

  assign o_expired = (count_q == {IW{1'b0}});

endmodule

// File: logic/fts_replay_clock.v
// Free-running tick clock and replay due compare
`timescale 1ns/10ps
module fts_replay_clock (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_tick,
  input  wire        i_clear,
  input  wire [31:0] i_stamp,
  output wire [31:0] o_now,
  output wire        o_due
);

  reg [31:0] now_q;

  // ******************************************************
  // Session time in ticks since start
  // ******************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      now_q <= 32'h00000000;
    end else if (i_clear) begin
      now_q <= 32'h00000000;
    end else if (i_tick) begin
      now_q <= now_q + 32'h00000001;
    end
  end

  assign o_now = now_q;
  assign o_due = (now_q >= i_stamp);

endmodule

// File: logic/fts_scheduler.v
// CAN frame timing scheduler with APB register access
`timescale 1ns/10ps
`include "fts_defs.vh"

module fts_scheduler #(
  parameter IW       = 16,
  parameter TICK_CYC = `FTS_TICK_CYC
) (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        o_tx_req,
  output wire [10:0] o_tx_id,
  output wire        o_tx_rtr,
  output wire [3:0]  o_tx_dlc,
  output wire [63:0] o_tx_data,
  input  wire        i_tx_done,
  input  wire        i_rx_valid,
  input  wire [10:0] i_rx_id,
  input  wire        i_rx_rtr,
  input  wire [3:0]  i_rx_dlc,
  input  wire [63:0] i_rx_data
);

  // ******************************************************
  // Registers
  // ******************************************************
  reg [6:0]    ctrl_q;
  reg [10:0]   frame_id_q;
  reg [IW-1:0] interval_q;
  reg [63:0]   tx_buf_q;
  reg [3:0]    tx_dlc_q;
  reg [31:0]   stamp_q;
  reg          pend_q;
  reg          rsp_q;
  reg          slot_full_q;
  reg [10:0]   slot_id_q;
  reg          slot_rtr_q;
  reg [3:0]    slot_dlc_q;
  reg [63:0]   slot_data_q;
  reg [31:0]   slot_stamp_q;
  reg          ovf_q;
  reg [63:0]   rx_data_q;
  reg [10:0]   rx_id_q;
  reg [3:0]    rx_dlc_q;
  reg          rx_rtr_q;
  reg          rx_new_q;
  reg [7:0]    sent_cnt_q;
  reg          running_q;
  reg [5:0]    presc_q;
  reg          tick_q;
  reg          busy_q;
  reg [10:0]   tx_id_q;
  reg          tx_rtr_q;
  reg [3:0]    tx_dlc_out_q;
  reg [63:0]   tx_data_q;
  reg          pready_q;
  reg          pslverr_q;
  reg [31:0]   prdata_q;
  reg          hit_d;
  reg [31:0]   rdata_d;

  wire          en       = ctrl_q[`FTS_CTRL_EN];
  wire          out_sess = ctrl_q[`FTS_CTRL_OUT];
  wire          stream   = ctrl_q[`FTS_CTRL_STREAM];
  wire [1:0]    tt       = ctrl_q[`FTS_CTRL_TT_HI:`FTS_CTRL_TT_LO];
  wire [1:0]    st       = ctrl_q[`FTS_CTRL_ST_HI:`FTS_CTRL_ST_LO];
  wire          rmt_tt   = tt[1];
  wire          start    = en & ~running_q;
  wire          expired;
  wire          due;
  wire [31:0]   now;
  wire          wr       = psel & penable & pready_q & pwrite;
  wire          rd       = psel & penable & pready_q & ~pwrite;
  wire          wr_cmd   = wr && paddr == `FTS_A_TX_CMD;
  wire          cmd_rtr  = pwdata[`FTS_CMD_RTR];
  wire          rx_match = i_rx_valid && i_rx_id == frame_id_q;

  // ******************************************************
  // Send decision
  // ******************************************************
  reg launch;
  reg launch_slot;
  reg launch_rtr;
  reg timed;

  always @* begin
    launch      = 1'b0;
    launch_slot = 1'b0;
    launch_rtr  = 1'b0;
    timed       = 1'b0;
    if (en && !start && !busy_q) begin
      if (stream) begin
        if (out_sess && slot_full_q) begin
          if (st == `FTS_ST_IMM) begin
            launch      = 1'b1;
            launch_slot = 1'b1;
          end else if (due) begin
            launch      = 1'b1;
            launch_slot = 1'b1;
          end
        end
      end else if (out_sess) begin
        case (tt)
          `FTS_TT_CYC_DATA: begin
            launch = expired;
            timed  = 1'b1;
          end
          `FTS_TT_EVT_DATA: begin
            launch = pend_q & expired;
            timed  = 1'b1;
          end
          default: begin
            launch = rsp_q;
          end
        endcase
      end else begin
        case (tt)
          `FTS_TT_CYC_RMT: begin
            launch     = expired;
            launch_rtr = 1'b1;
            timed      = 1'b1;
          end
          `FTS_TT_EVT_RMT: begin
            launch     = pend_q;
            launch_rtr = 1'b1;
          end
          default: begin
            launch = 1'b0;
          end
        endcase
      end
    end
  end

  // ******************************************************
  // Tick prescaler and timers
  // ******************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      presc_q <= 6'h00;
      tick_q  <= 1'b0;
    end else if (presc_q == TICK_CYC[5:0] - 6'h01) begin
      presc_q <= 6'h00;
      tick_q  <= 1'b1;
    end else begin
      presc_q <= presc_q + 6'h01;
      tick_q  <= 1'b0;
    end
  end

  fts_interval_timer #(
    .IW (IW)
  ) u_timer (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_tick     (tick_q),
    .i_clear    (start),
    .i_reload   (launch & timed),
    .i_interval (interval_q),
    .o_expired  (expired)
  );

  fts_replay_clock u_clock (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_tick   (tick_q),
    .i_clear  (start),
    .i_stamp  (slot_stamp_q),
    .o_now    (now),
    .o_due    (due)
  );

  // ******************************************************
  // Transmit request toward the controller
  // ******************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_q       <= 1'b0;
      tx_id_q      <= 11'h000;
      tx_rtr_q     <= 1'b0;
      tx_dlc_out_q <= 4'h0;
      tx_data_q    <= 64'h0000000000000000;
      sent_cnt_q   <= 8'h00;
      running_q    <= 1'b0;
    end else begin
      running_q <= en;
      if (!en) begin
        busy_q <= 1'b0;
      end else if (launch) begin
        busy_q <= 1'b1;
        if (launch_slot) begin
          tx_id_q      <= slot_id_q;
          tx_rtr_q     <= slot_rtr_q;
          tx_dlc_out_q <= slot_dlc_q;
          tx_data_q    <= slot_data_q;
        end else begin
          tx_id_q      <= frame_id_q;
          tx_rtr_q     <= launch_rtr;
          tx_dlc_out_q <= tx_dlc_q;
          tx_data_q    <= tx_buf_q;
        end
      end else if (i_tx_done) begin
        busy_q     <= 1'b0;
        sent_cnt_q <= sent_cnt_q + 8'h01;
      end
    end
  end

  // ******************************************************
  // Host writes, pending events and stream slot
  // ******************************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q       <= `FTS_CTRL_RST;
      frame_id_q   <= 11'h000;
      interval_q   <= `FTS_INTERVAL_RST;
      tx_buf_q     <= 64'h0000000000000000;
      tx_dlc_q     <= 4'h0;
      stamp_q      <= 32'h00000000;
      pend_q       <= 1'b0;
      rsp_q        <= 1'b0;
      slot_full_q  <= 1'b0;
      slot_id_q    <= 11'h000;
      slot_rtr_q   <= 1'b0;
      slot_dlc_q   <= 4'h0;
      slot_data_q  <= 64'h0000000000000000;
      slot_stamp_q <= 32'h00000000;
      ovf_q        <= 1'b0;
    end else begin
      if (wr) begin
        case (paddr)
          `FTS_A_CTRL:     ctrl_q     <= pwdata[6:0];
          `FTS_A_FRAME_ID: frame_id_q <= pwdata[10:0];
          `FTS_A_INTERVAL: interval_q <= pwdata[IW-1:0];
          `FTS_A_TX_LO:    tx_buf_q[31:0]  <= pwdata;
          `FTS_A_TX_HI:    tx_buf_q[63:32] <= pwdata;
          `FTS_A_TX_STAMP: stamp_q    <= pwdata;
          `FTS_A_STATUS:   ovf_q      <= ovf_q & ~pwdata[4];
          default: begin
          end
        endcase
      end
      // Launches consume events; a write in the same cycle wins
      if (launch && !launch_slot && !timed) begin
        rsp_q  <= 1'b0;
        pend_q <= 1'b0;
      end else if (launch && tt == `FTS_TT_EVT_DATA) begin
        pend_q <= 1'b0;
      end
      if (launch_slot) begin
        slot_full_q <= 1'b0;
      end
      if (!en) begin
        pend_q      <= 1'b0;
        rsp_q       <= 1'b0;
        slot_full_q <= 1'b0;
      end else begin
        if (!stream && out_sess && rmt_tt && rx_match && i_rx_rtr) begin
          rsp_q <= 1'b1;
        end
        if (wr_cmd) begin
          if (stream && out_sess) begin
            if (slot_full_q && !launch_slot) begin
              ovf_q <= 1'b1;
            end else begin
              slot_full_q  <= 1'b1;
              slot_id_q    <= pwdata[`FTS_ID_HI:`FTS_ID_LO];
              slot_rtr_q   <= cmd_rtr;
              slot_dlc_q   <= pwdata[3:0];
              slot_data_q  <= tx_buf_q;
              slot_stamp_q <= stamp_q;
            end
          end else if (!stream && out_sess && !rmt_tt) begin
            if (!cmd_rtr) begin
              tx_dlc_q <= pwdata[3:0];
              if (tt == `FTS_TT_EVT_DATA) begin
                pend_q <= 1'b1;
              end
            end
          end else if (!stream && out_sess) begin
            tx_dlc_q <= pwdata[3:0];
          end else if (!stream && tt == `FTS_TT_EVT_RMT) begin
            pend_q <= 1'b1;
          end
        end
      end
    end
  end

  // ******************************************************
  // Receive capture
  // ******************************************************
  wire rx_take = en && !out_sess && i_rx_valid &&
                 (stream || (rx_match && !i_rx_rtr));
  wire info_rd = rd && paddr == `FTS_A_RX_INFO;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_data_q <= 64'h0000000000000000;
      rx_id_q   <= 11'h000;
      rx_dlc_q  <= 4'h0;
      rx_rtr_q  <= 1'b0;
      rx_new_q  <= 1'b0;
    end else if (rx_take) begin
      rx_data_q <= i_rx_data;
      rx_id_q   <= i_rx_id;
      rx_dlc_q  <= i_rx_dlc;
      rx_rtr_q  <= i_rx_rtr;
      rx_new_q  <= 1'b1;
    end else if (info_rd) begin
      rx_new_q <= 1'b0;
    end
  end

  // ******************************************************
  // APB read mux and handshake
  // ******************************************************
  always @* begin
    hit_d   = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr)
      `FTS_A_CTRL:     rdata_d = {25'h0000000, ctrl_q};
      `FTS_A_FRAME_ID: rdata_d = {21'h000000, frame_id_q};
      `FTS_A_INTERVAL: rdata_d = {{(32-IW){1'b0}}, interval_q};
      `FTS_A_TX_LO:    rdata_d = tx_buf_q[31:0];
      `FTS_A_TX_HI:    rdata_d = tx_buf_q[63:32];
      `FTS_A_TX_CMD:   rdata_d = {5'h00, slot_id_q, 11'h000, slot_rtr_q, tx_dlc_q};
      `FTS_A_TX_STAMP: rdata_d = stamp_q;
      `FTS_A_RX_LO:    rdata_d = rx_data_q[31:0];
      `FTS_A_RX_HI:    rdata_d = rx_data_q[63:32];
      `FTS_A_RX_INFO:  rdata_d = {5'h00, rx_id_q, 10'h000, rx_new_q, rx_rtr_q, rx_dlc_q};
      `FTS_A_STATUS:   rdata_d = {16'h0000, sent_cnt_q, 3'h0, ovf_q,
                                  slot_full_q, busy_q, pend_q | rsp_q, running_q};
      `FTS_A_NOW:      rdata_d = now;
      default:         hit_d   = 1'b0;
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit_d;
      prdata_q  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h00000000;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign o_tx_req  = busy_q;
  assign o_tx_id   = tx_id_q;
  assign o_tx_rtr  = tx_rtr_q;
  assign o_tx_dlc  = tx_dlc_out_q;
  assign o_tx_data = tx_data_q;

endmodule

// File: bench/fts_sched_props.sv
// Port assertions of the frame scheduler
`timescale 1ns/10ps
`include "fts_defs.vh"
module fts_sched_props #(
  parameter IW       = 16,
  parameter TICK_CYC = 4
) (
  input wire        i_clk,
  input wire        i_resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        o_tx_req,
  input wire [10:0] o_tx_id,
  input wire        o_tx_rtr,
  input wire [3:0]  o_tx_dlc,
  input wire [63:0] o_tx_data,
  input wire        i_tx_done,
  input wire        i_rx_valid,
  input wire [10:0] i_rx_id,
  input wire        i_rx_rtr,
  input wire [3:0]  i_rx_dlc,
  input wire [63:0] i_rx_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire ctl_wr = psel && penable && pwrite && pready && paddr == `FTS_A_CTRL;
  // ***
  // Host access and transmit link
  // ***
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  a_ready_only: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  a_err_unmap: assert property (psel && !penable && (paddr > 8'h2C || paddr[1:0] != 2'b00) |=>
    pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (psel && !penable && paddr <= 8'h2C && paddr[1:0] == 2'b00 |=>
    !pslverr)
    else $error("mapped access refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_tx_hold: assert property (o_tx_req && !i_tx_done && !ctl_wr |=>
    o_tx_req && $stable({o_tx_id, o_tx_rtr, o_tx_dlc, o_tx_data}))
    else $error("frame changed in flight");
  a_tx_release: assert property (o_tx_req && i_tx_done |=> !o_tx_req)
    else $error("request held after done");
  a_off_quiet: assert property (ctl_wr && !pwdata[0] |=> ##1 !o_tx_req [*2])
    else $error("send while disabled");
  c_remote: cover property ($rose(o_tx_req) && o_tx_rtr);
  c_unmap: cover property (pslverr);
  c_rx_rmt: cover property (i_rx_valid && i_rx_rtr);
endmodule

bind fts_scheduler fts_sched_props #(.IW(IW), .TICK_CYC(TICK_CYC)) u_props (
  .i_clk(i_clk), .i_resetn(i_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .o_tx_req(o_tx_req), .o_tx_id(o_tx_id), .o_tx_rtr(o_tx_rtr), .o_tx_dlc(o_tx_dlc),
  .o_tx_data(o_tx_data), .i_tx_done(i_tx_done), .i_rx_valid(i_rx_valid),
  .i_rx_id(i_rx_id), .i_rx_rtr(i_rx_rtr), .i_rx_dlc(i_rx_dlc), .i_rx_data(i_rx_data));

// File: bench/fts_bus_model.sv
// Behavioural CAN controller and remote nodes facing the scheduler
`timescale 1ns/10ps
module fts_bus_model (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire        i_tx_req,
  input  wire [10:0] i_tx_id,
  input  wire        i_tx_rtr,
  input  wire [3:0]  i_tx_dlc,
  input  wire [63:0] i_tx_data,
  output logic       o_tx_done,
  output logic       o_rx_valid,
  output logic [10:0] o_rx_id,
  output logic       o_rx_rtr,
  output logic [3:0] o_rx_dlc,
  output logic [63:0] o_rx_data
);
  int          cyc, t0, gap, wt, lat;
  logic        act, last_rtr;
  logic [7:0]  cnt;
  logic [10:0] last_id;
  logic [3:0]  last_dlc;
  logic [63:0] last_data;
  initial begin
    lat = 3;
    o_rx_valid = 1'b0;
    o_rx_id = 11'h0;
    o_rx_rtr = 1'b0;
    o_rx_dlc = 4'h0;
    o_rx_data = 64'h0;
  end
  // Takes each launched frame, answers lat+1 cycles later
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_done <= 1'b0;
      act <= 1'b0;
      cnt <= 8'h0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      o_tx_done <= 1'b0;
      if (i_tx_req && !act && !o_tx_done) begin
        act <= 1'b1;
        wt <= lat;
        cnt <= cnt + 8'h1;
        gap <= cyc - t0;
        t0 <= cyc;
        last_id <= i_tx_id;
        last_rtr <= i_tx_rtr;
        last_dlc <= i_tx_dlc;
        last_data <= i_tx_data;
      end else if (act && wt > 0) begin
        wt <= wt - 1;
      end else if (act) begin
        o_tx_done <= 1'b1;
        act <= 1'b0;
      end
    end
  end
  // One received frame, then the lines show the inverse
  task inject(input logic [10:0] id, input logic r, input logic [3:0] dl, input logic [63:0] d);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_id <= id;
    o_rx_rtr <= r;
    o_rx_dlc <= dl;
    o_rx_data <= d;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_id <= ~id;
    o_rx_rtr <= ~r;
    o_rx_dlc <= ~dl;
    o_rx_data <= ~d;
  endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the frame scheduler
`timescale 1ns/10ps
`include "fts_defs.vh"
module tb_top;
  localparam int T  = 4;
  localparam int IV = 3;
  logic        clk, resetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rdat;
  wire  [31:0] prdata;
  wire         pready, pslverr, tx_req, tx_rtr, tx_done, rx_valid, rx_rtr;
  wire  [10:0] tx_id, rx_id;
  wire  [3:0]  tx_dlc, rx_dlc;
  wire  [63:0] tx_data, rx_data;
  int          bad_count, cmp_count, c;
  fts_scheduler #(.TICK_CYC(T)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_tx_req(tx_req), .o_tx_id(tx_id), .o_tx_rtr(tx_rtr), .o_tx_dlc(tx_dlc),
    .o_tx_data(tx_data), .i_tx_done(tx_done), .i_rx_valid(rx_valid), .i_rx_id(rx_id),
    .i_rx_rtr(rx_rtr), .i_rx_dlc(rx_dlc), .i_rx_data(rx_data));
  fts_bus_model u_bus (
    .i_clk(clk), .i_resetn(resetn), .i_tx_req(tx_req), .i_tx_id(tx_id), .i_tx_rtr(tx_rtr),
    .i_tx_dlc(tx_dlc), .i_tx_data(tx_data), .o_tx_done(tx_done), .o_rx_valid(rx_valid),
    .o_rx_id(rx_id), .o_rx_rtr(rx_rtr), .o_rx_dlc(rx_dlc), .o_rx_data(rx_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ***
  // Access tasks
  // ***
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task mode(input logic [31:0] v);
    wr(`FTS_A_CTRL, 32'h0);
    wr(`FTS_A_CTRL, v);
  endtask
  task wcnt(input logic [7:0] n, input int lim);
    int k;
    k = 0;
    while (u_bus.cnt < n && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(u_bus.cnt, n);
  endtask
  task idle(input int k);
    c = u_bus.cnt;
    repeat (k) @(posedge clk);
    chk(u_bus.cnt, c);
  endtask
  task fr(input logic r, input logic [10:0] id);
    chk({u_bus.last_rtr, u_bus.last_id}, {r, id});
  endtask
  task wrap_up();
    $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  // ***
  // Scenarios
  // ***
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(`FTS_A_CTRL, 32'h0);
    rd(`FTS_A_INTERVAL, `FTS_INTERVAL_RST);
    wr(8'h30, 32'hFF);
    chk(err, 1'b1);
    wr(`FTS_A_FRAME_ID, 32'h123);
    wr(`FTS_A_INTERVAL, IV);
    wr(`FTS_A_TX_LO, 32'hA5A50001);
    wr(`FTS_A_TX_HI, 32'h5A5A0002);
    wr(`FTS_A_CTRL, 32'h3);
    wr(`FTS_A_TX_CMD, 32'h8);
    wcnt(1, 6);
    chk(u_bus.last_data, 64'h5A5A0002A5A50001);
    wcnt(3, 60);
    chk({u_bus.last_dlc, u_bus.last_data}, {4'h8, 64'h5A5A0002A5A50001});
    chk(64'(u_bus.gap >= IV*T-T && u_bus.gap <= IV*T+T+2), 64'h1);
    mode(32'hB);
    idle(60);
    wr(`FTS_A_TX_CMD, 32'h4);
    wcnt(c + 1, 40);
    wr(`FTS_A_TX_CMD, 32'h4);
    wcnt(c + 2, 40);
    chk(64'(u_bus.gap >= IV*T-T), 64'h1);
    chk({u_bus.last_rtr, u_bus.last_dlc}, {1'b0, 4'h4});
    idle(80);
    wr(`FTS_A_TX_CMD, 32'h14);
    idle(60);
    mode(32'h7);
    c = u_bus.cnt;
    wr(`FTS_A_TX_CMD, 32'h02AB0010);
    wcnt(c + 1, 6);
    fr(1'b1, 11'h2AB);
    wr(`FTS_A_TX_CMD, 32'h00550002);
    wcnt(c + 2, 12);
    fr(1'b0, 11'h055);
    idle(80);
    for (int s = 1; s < 3; s++) begin
      mode(32'h7 | (s << 5));
      c = u_bus.cnt;
      wr(`FTS_A_TX_STAMP, 32'h6);
      wr(`FTS_A_TX_CMD, 32'h01110001);
      chk(u_bus.cnt, c);
      wr(`FTS_A_TX_CMD, 32'h01110003);
      apb(1'b0, `FTS_A_STATUS, 32'h0);
      chk(rdat[7:0], 8'h19);
      wr(`FTS_A_STATUS, 32'h10);
      wcnt(c + 1, 60);
      chk(u_bus.last_dlc, 4'h1);
      apb(1'b0, `FTS_A_NOW, 32'h0);
      chk(64'(rdat >= 6 && rdat <= 8), 64'h1);
    end
    mode(32'h1);
    u_bus.inject(11'h123, 1'b0, 4'h8, 64'h1122334455667788);
    rd(`FTS_A_RX_LO, 32'h55667788);
    rd(`FTS_A_RX_HI, 32'h11223344);
    rd(`FTS_A_RX_INFO, 32'h01230028);
    u_bus.inject(11'h123, 1'b1, 4'h0, 64'h0);
    u_bus.inject(11'h124, 1'b0, 4'h3, 64'h9);
    rd(`FTS_A_RX_INFO, 32'h01230008);
    rd(`FTS_A_RX_LO, 32'h55667788);
    mode(32'h5);
    u_bus.inject(11'h3C1, 1'b1, 4'h0, 64'h0);
    rd(`FTS_A_RX_INFO, 32'h03C10030);
    wr(`FTS_A_CTRL, 32'h0);
    c = u_bus.cnt;
    wr(`FTS_A_CTRL, 32'h11);
    wcnt(c + 1, 20);
    fr(1'b1, 11'h123);
    mode(32'h19);
    c = u_bus.cnt;
    wr(`FTS_A_TX_CMD, 32'h0);
    wcnt(c + 1, 10);
    fr(1'b1, 11'h123);
    mode(32'h13);
    idle(30);
    u_bus.inject(11'h123, 1'b1, 4'h0, 64'h0);
    wcnt(c + 1, 10);
    fr(1'b0, 11'h123);
    wrap_up();
  end
endmodule
